// file: design/scc_pkg.sv
// Notes on behaviour
// R01: audio word is payload bits 4 to 27
// R02: sample length 16 to 20, or 20 to 24 bits
// R03: source signals length in status fields
// R04: unmasked, cut word to signalled length
// R05: mask set passes all 24 bits
// R06: narrow port drops low bits, always
// R07: wide port zero-fills unused low bits
// R08: transmitter gets full word unless truncated
// R09: capture status from first channel only
// R10: three read-only status registers, readable
// R11: changed block updates registers, raises interrupt
// R12: interrupt holds until a status read
// R13: new change drops interrupt, reasserts later
// R14: user data routed to general outputs
// R15: first register holds status bits 0-7
// R16: second register holds category, bits 15:8
// R17: third register: source and channel numbers
// R18: channel codes 00 unused, 01 left, 10 right
// R19: truncation zeroes low bits, no shift
// R20: truncation mask is config bit 6
// R21: status registers read zero after reset
package scc_pkg;
  // ***************************************************************
  // stream layout
  // ***************************************************************
  localparam int AUDIO_W = 24;
  localparam int AUDIO_LSB = 4;
  localparam int AUDIO_MSB = 27;
  localparam int PAYLOAD_W = 28;
  localparam int BLOCK_BITS = 192;
  localparam logic [7:0] BLOCK_LAST = 8'hbf;
  localparam int CAP_BITS = 40;
  localparam logic [7:0] CAP_LIMIT = 8'h28;
  localparam int MAXLEN_POS = 32;
  localparam int LENCODE_LSB = 33;
  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [6:0] ADDR_STATUS_BYTE_ZERO = 7'h0d;
  localparam logic [6:0] ADDR_CATEGORY_BYTE = 7'h0e;
  localparam logic [6:0] ADDR_SOURCE_CHANNEL_BYTE = 7'h0f;
  localparam logic [6:0] ADDR_PORT_CFG = 7'h1b;
  localparam logic [6:0] ADDR_RX_CFG = 7'h1c;
  localparam int CFG_GPO_EN_BIT = 5;
  localparam int CFG_MASK_BIT = 6;
  localparam logic [7:0] RX_CFG_RESET = 8'h80;
  localparam logic [7:0] PORT_CFG_RESET = 8'h02;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [39:0] SHADOW_RESET = 40'h00_0000_0000;
  // ***************************************************************
  // port word widths and signalled lengths
  // ***************************************************************
  localparam logic [1:0] PORT_W16 = 2'h0;
  localparam logic [1:0] PORT_W20 = 2'h1;
  localparam logic [1:0] PORT_W24 = 2'h2;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_17 = 5'h11;
  localparam logic [4:0] LEN_18 = 5'h12;
  localparam logic [4:0] LEN_19 = 5'h13;
  localparam logic [4:0] LEN_20 = 5'h14;
  localparam logic [4:0] LEN_21 = 5'h15;
  localparam logic [4:0] LEN_22 = 5'h16;
  localparam logic [4:0] LEN_23 = 5'h17;
  localparam logic [4:0] LEN_24 = 5'h18;
  localparam logic [2:0] CODE_A = 3'h1;
  localparam logic [2:0] CODE_B = 3'h2;
  localparam logic [2:0] CODE_C = 3'h4;
  localparam logic [2:0] CODE_D = 3'h5;
  localparam logic [2:0] CODE_E = 3'h6;
  localparam logic [1:0] CHAN_UNUSED = 2'h0;
  localparam logic [1:0] CHAN_LEFT = 2'h1;
  localparam logic [1:0] CHAN_RIGHT = 2'h2;
endpackage

// file: design/scc_rx_status.sv
`timescale 1ns/1ps
`default_nettype none
module scc_rx_status #(
  parameter int AW = scc_pkg::AUDIO_W
) (
  // system clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [6:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_status_change_irq,
  // recovered receive clock and sub-frame stream
  input wire logic i_rx_clk,
  input wire logic i_sub_valid,
  input wire logic i_sub_first,
  input wire logic i_block_start,
  input wire logic [scc_pkg::PAYLOAD_W-1:0] i_sub_payload,
  input wire logic i_sub_cs,
  input wire logic i_sub_user,
  // samples out, receive clock
  output logic o_sample_valid,
  output logic o_sample_first,
  output logic [AW-1:0] o_adp_word,
  output logic [AW-1:0] o_tx_word,
  // user data on general output
  output logic o_general_output_pin,
  output logic o_general_output_en
);
  // ***************************************************************
  // receive clock domain
  // ***************************************************************
  logic [3:0] cfg_l;
  logic [1:0] port_w_l;
  logic mask_l;
  logic gpo_en_l;
  logic in_block_reg;
  logic [7:0] bit_idx_reg;
  logic [7:0] cur_idx;
  logic [scc_pkg::CAP_BITS-1:0] cap_reg;
  logic [scc_pkg::CAP_BITS-1:0] shadow_reg;
  logic diff_seen_reg;
  logic diff_tgl_reg;
  logic upd_tgl_reg;
  logic cs_take;
  logic cs_differs;
  logic block_end;
  logic [AW-1:0] audio_word;
  logic [AW-1:0] tx_word_next;
  logic [AW-1:0] port_word_next;
  logic [4:0] sig_len;
  logic [7:0] rx_cfg_reg;
  logic [7:0] port_cfg_reg;

  // config is quasi-static, so a plain two-stage crossing per bit is enough
  scc_sync2 #(.W(4)) u_cfg_sync (
    .i_clk(i_rx_clk),
    .i_rst(i_rst),
    .i_d({rx_cfg_reg[scc_pkg::CFG_GPO_EN_BIT], rx_cfg_reg[scc_pkg::CFG_MASK_BIT],
          port_cfg_reg[1:0]}),
    .o_q(cfg_l)
  );
  assign gpo_en_l = cfg_l[3];
  assign mask_l = cfg_l[2];
  assign port_w_l = cfg_l[1:0];

  assign audio_word = i_sub_payload[scc_pkg::AUDIO_MSB:scc_pkg::AUDIO_LSB]; // R01

  scc_trunc #(.AW(AW)) u_trunc (
    .i_word(audio_word),
    .i_max_length_flag(shadow_reg[scc_pkg::MAXLEN_POS]), // R02 R03
    .i_signalled_length_code(shadow_reg[scc_pkg::LENCODE_LSB +: 3]),
    .i_truncation_mask(mask_l),
    .i_port_w(port_w_l),
    .o_tx_word(tx_word_next),
    .o_port_word(port_word_next),
    .o_len(sig_len)
  );

  always_ff @(posedge i_rx_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sample_valid <= 1'b0;
      o_sample_first <= 1'b0;
      o_adp_word <= '0;
      o_tx_word <= '0;
    end else begin
      o_sample_valid <= i_sub_valid;
      if (i_sub_valid) begin
        o_sample_first <= i_sub_first;
        o_adp_word <= port_word_next; // R06 R07
        o_tx_word <= tx_word_next; // R08
      end
    end
  end

  always_ff @(posedge i_rx_clk or posedge i_rst) begin
    if (i_rst) begin
      o_general_output_pin <= 1'b0;
      o_general_output_en <= 1'b0;
    end else begin
      o_general_output_en <= gpo_en_l;
      if (!gpo_en_l) begin
        o_general_output_pin <= 1'b0;
      end else if (i_sub_valid) begin
        o_general_output_pin <= i_sub_user; // R14
      end
    end
  end

  // ***************************************************************
  // channel status capture, first channel only
  // ***************************************************************
  assign cs_take = i_sub_valid && i_sub_first && (in_block_reg || i_block_start); // R09
  assign cur_idx = i_block_start ? 8'h00 : bit_idx_reg;
  assign cs_differs = (cur_idx < scc_pkg::CAP_LIMIT) &&
                      (i_sub_cs != shadow_reg[cur_idx[5:0]]);
  assign block_end = cs_take && (cur_idx == scc_pkg::BLOCK_LAST);

  always_ff @(posedge i_rx_clk or posedge i_rst) begin
    if (i_rst) begin
      in_block_reg <= 1'b0;
      bit_idx_reg <= 8'h00;
    end else if (cs_take) begin
      // a lost block start drops sync until the next one
      in_block_reg <= !block_end;
      bit_idx_reg <= cur_idx + 8'h01;
    end
  end

  always_ff @(posedge i_rx_clk or posedge i_rst) begin
    if (i_rst) begin
      cap_reg <= '0;
    end else if (cs_take && (cur_idx < scc_pkg::CAP_LIMIT)) begin
      cap_reg[cur_idx[5:0]] <= i_sub_cs; // R09
    end
  end

  always_ff @(posedge i_rx_clk or posedge i_rst) begin
    if (i_rst) begin
      diff_seen_reg <= 1'b0;
      diff_tgl_reg <= 1'b0;
    end else if (cs_take) begin
      if (block_end) begin
        diff_seen_reg <= 1'b0;
      end else if (cs_differs && (i_block_start || !diff_seen_reg)) begin
        diff_seen_reg <= 1'b1;
        diff_tgl_reg <= !diff_tgl_reg; // R13
      end else if (i_block_start) begin
        diff_seen_reg <= 1'b0;
      end
    end
  end

  // shadow stays still for a whole block, so the system side may read it directly
  always_ff @(posedge i_rx_clk or posedge i_rst) begin
    if (i_rst) begin
      shadow_reg <= scc_pkg::SHADOW_RESET; // R21
      upd_tgl_reg <= 1'b0;
    end else if (block_end && diff_seen_reg) begin
      shadow_reg <= cap_reg; // R11
      upd_tgl_reg <= !upd_tgl_reg; // R11
    end
  end

  // ***************************************************************
  // system clock domain
  // ***************************************************************
  logic [1:0] tgl_s;
  logic upd_seen_reg;
  logic diff_seen_s_reg;
  logic upd_evt;
  logic diff_evt;
  logic status_rd;
  logic [7:0] status_byte_zero_reg;
  logic [7:0] category_byte_reg;
  logic [7:0] source_channel_byte_reg;
  logic [7:0] rdata_next;

  scc_sync2 #(.W(2)) u_evt_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({upd_tgl_reg, diff_tgl_reg}),
    .o_q(tgl_s)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      upd_seen_reg <= 1'b0;
      diff_seen_s_reg <= 1'b0;
    end else begin
      upd_seen_reg <= tgl_s[1];
      diff_seen_s_reg <= tgl_s[0];
    end
  end
  assign upd_evt = tgl_s[1] ^ upd_seen_reg;
  assign diff_evt = tgl_s[0] ^ diff_seen_s_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_byte_zero_reg <= scc_pkg::STATUS_RESET; // R21
      category_byte_reg <= scc_pkg::STATUS_RESET;
      source_channel_byte_reg <= scc_pkg::STATUS_RESET;
    end else if (upd_evt) begin
      status_byte_zero_reg <= shadow_reg[7:0]; // R10 R15
      category_byte_reg <= shadow_reg[15:8]; // R16
      // channel codes are carried as received: 00 unused, 01 left, 10 right
      source_channel_byte_reg <= shadow_reg[23:16]; // R17 R18
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_cfg_reg <= scc_pkg::RX_CFG_RESET;
      port_cfg_reg <= scc_pkg::PORT_CFG_RESET;
    end else if (i_reg_wr) begin
      if (i_reg_addr == scc_pkg::ADDR_RX_CFG) begin
        rx_cfg_reg <= i_reg_wdata; // R20
      end
      if (i_reg_addr == scc_pkg::ADDR_PORT_CFG) begin
        port_cfg_reg <= {6'h00, i_reg_wdata[1:0]};
      end
    end
  end

  assign status_rd = i_reg_rd && ((i_reg_addr == scc_pkg::ADDR_STATUS_BYTE_ZERO) ||
                                  (i_reg_addr == scc_pkg::ADDR_CATEGORY_BYTE) ||
                                  (i_reg_addr == scc_pkg::ADDR_SOURCE_CHANNEL_BYTE));

  always_comb begin
    case (i_reg_addr)
      scc_pkg::ADDR_STATUS_BYTE_ZERO: rdata_next = status_byte_zero_reg;
      scc_pkg::ADDR_CATEGORY_BYTE: rdata_next = category_byte_reg;
      scc_pkg::ADDR_SOURCE_CHANNEL_BYTE: rdata_next = source_channel_byte_reg;
      scc_pkg::ADDR_RX_CFG: rdata_next = rx_cfg_reg;
      scc_pkg::ADDR_PORT_CFG: rdata_next = port_cfg_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_next; // R10
    end
  end

  // a completed change wins over a read or a fresh difference in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_status_change_irq <= 1'b0;
    end else if (upd_evt) begin
      o_status_change_irq <= 1'b1; // R11
    end else if (status_rd || diff_evt) begin
      o_status_change_irq <= 1'b0; // R12 R13
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  chk_irq_on_update: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    upd_evt |=> o_status_change_irq)
    else $error("interrupt not raised after status update");

  chk_irq_read_clear: assert property (@(posedge i_clk) disable iff (i_rst) // R12
    status_rd && !upd_evt |=> !o_status_change_irq)
    else $error("interrupt not cleared by status read");

  chk_irq_holds: assert property (@(posedge i_clk) disable iff (i_rst) // R12
    o_status_change_irq && !status_rd && !diff_evt |=> o_status_change_irq)
    else $error("interrupt dropped without cause");

  chk_irq_diff_drop: assert property (@(posedge i_clk) disable iff (i_rst) // R13
    diff_evt && !upd_evt |=> !o_status_change_irq)
    else $error("interrupt not dropped on new difference");

  chk_regs_follow_block: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    upd_evt |=> (category_byte_reg == $past(shadow_reg[15:8])) &&
                (status_byte_zero_reg == $past(shadow_reg[7:0])))
    else $error("status registers not loaded from block");

  chk_read_category: assert property (@(posedge i_clk) disable iff (i_rst) // R16
    i_reg_rd && (i_reg_addr == scc_pkg::ADDR_CATEGORY_BYTE) |=>
      o_reg_rdata == $past(category_byte_reg))
    else $error("category read returns wrong value");

  chk_mask_passes: assert property (@(posedge i_rx_clk) disable iff (i_rst) // R05
    i_sub_valid && mask_l |=> o_tx_word == $past(audio_word))
    else $error("masked word was altered");

  chk_narrow_port: assert property (@(posedge i_rx_clk) disable iff (i_rst) // R06
    i_sub_valid && (port_w_l == scc_pkg::PORT_W16) |=> o_adp_word[7:0] == 8'h00)
    else $error("low bits not dropped for narrow port");

  chk_trunc_twenty: assert property (@(posedge i_rx_clk) disable iff (i_rst) // R04
    i_sub_valid && !mask_l && (sig_len == scc_pkg::LEN_20) |=>
      (o_tx_word[3:0] == 4'h0) && (o_tx_word[23:4] == $past(audio_word[23:4])))
    else $error("truncation to twenty bits wrong");

  chk_second_channel: assert property (@(posedge i_rx_clk) disable iff (i_rst) // R09
    i_sub_valid && !i_sub_first |=> $stable(cap_reg) && $stable(bit_idx_reg))
    else $error("status captured from second channel");
endmodule
`default_nettype wire

// file: design/scc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module scc_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_reg;

  // first stage feeds the second and nothing else
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= '0;
      o_q <= '0;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: design/scc_trunc.sv
`timescale 1ns/1ps
`default_nettype none
module scc_trunc #(
  parameter int AW = scc_pkg::AUDIO_W
) (
  // sample and signalled length
  input wire logic [AW-1:0] i_word,
  input wire logic i_max_length_flag,
  input wire logic [2:0] i_signalled_length_code,
  input wire logic i_truncation_mask,
  input wire logic [1:0] i_port_w,
  // results
  output logic [AW-1:0] o_tx_word,
  output logic [AW-1:0] o_port_word,
  output logic [4:0] o_len
);
  logic [4:0] len;
  logic [4:0] port_len;
  logic [AW-1:0] len_keep;
  logic [AW-1:0] port_keep;

  always_comb begin
    len = scc_pkg::LEN_24;
    case (i_signalled_length_code)
      scc_pkg::CODE_A: len = i_max_length_flag ? scc_pkg::LEN_20 : scc_pkg::LEN_16;
      scc_pkg::CODE_B: len = i_max_length_flag ? scc_pkg::LEN_22 : scc_pkg::LEN_18;
      scc_pkg::CODE_C: len = i_max_length_flag ? scc_pkg::LEN_23 : scc_pkg::LEN_19;
      scc_pkg::CODE_D: len = i_max_length_flag ? scc_pkg::LEN_24 : scc_pkg::LEN_20;
      scc_pkg::CODE_E: len = i_max_length_flag ? scc_pkg::LEN_21 : scc_pkg::LEN_17;
      // not indicated or reserved: leave the word whole
      default: len = scc_pkg::LEN_24;
    endcase
  end

  always_comb begin
    case (i_port_w)
      scc_pkg::PORT_W16: port_len = scc_pkg::LEN_16;
      scc_pkg::PORT_W20: port_len = scc_pkg::LEN_20;
      default: port_len = scc_pkg::LEN_24;
    endcase
  end

  // bit b survives when it lies among the top len bits
  for (genvar b = 0; b < AW; b++) begin : g_keep
    assign len_keep[b] = i_truncation_mask || (5'(b) >= (scc_pkg::LEN_24 - len)); // R04 R05 R20
    assign port_keep[b] = 5'(b) >= (scc_pkg::LEN_24 - port_len); // R06 R07
  end

  assign o_len = len;
  assign o_tx_word = i_word & len_keep; // R08 R19
  assign o_port_word = i_word & len_keep & port_keep; // R06 R07 R19
endmodule
`default_nettype wire

// file: tb/scc_rx_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scc_rx_status_tb;
  logic i_clk, i_rst, rx_clk, reg_rd, reg_wr;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, rdata, d;
  logic irq, s_valid, s_first, blk, cs, user, smp_valid, smp_first, general_output_pin, gpo_en;
  logic [27:0] payload;
  logic [23:0] adp, tx;
  int n_errors, comparisons, n_samples;
  // status blocks, bits 39:0
  localparam logic [39:0] ST1 = 40'h09_00_95_42_06;
  localparam logic [39:0] ST2 = 40'h0a_00_62_00_04;
  localparam logic [39:0] ST3 = 40'h0a_00_62_00_06;
  localparam logic [39:0] ST4 = 40'h04_00_62_00_06;

  // ***************************************************************
  // clocks and instances
  // ***************************************************************
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    rx_clk = 1'b0;
    #1.7;
    forever #3 rx_clk = ~rx_clk;
  end

  scc_src_model u_src (.i_rx_clk(rx_clk), .o_sub_valid(s_valid), .o_sub_first(s_first),
    .o_block_start(blk), .o_sub_payload(payload), .o_sub_cs(cs), .o_sub_user(user));

  scc_rx_status u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(reg_addr),
    .i_reg_rd(reg_rd), .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
    .o_status_change_irq(irq), .i_rx_clk(rx_clk), .i_sub_valid(s_valid),
    .i_sub_first(s_first), .i_block_start(blk), .i_sub_payload(payload), .i_sub_cs(cs),
    .i_sub_user(user), .o_sample_valid(smp_valid), .o_sample_first(smp_first),
    .o_adp_word(adp), .o_tx_word(tx), .o_general_output_pin(general_output_pin),
    .o_general_output_en(gpo_en));

  // count sample pulses away from the edge that launches them
  always @(negedge rx_clk) begin
    if (smp_valid) begin
      n_samples++;
    end
  end

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd8(input logic [6:0] a, output logic [7:0] v);
    @(negedge i_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge i_clk);
    reg_rd = 1'b0;
    @(negedge i_clk);
    v = rdata;
  endtask

  task automatic wr8(input logic [6:0] a, input logic [7:0] v);
    @(negedge i_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge i_clk);
    reg_wr = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask

  // one second-channel sample, then let both domains settle
  task automatic sample(input logic [23:0] audio, input logic ub);
    u_src.send_sub(1'b0, 1'b0, 1'b0, ub, audio);
    repeat (4) @(negedge i_clk);
  endtask

  task automatic final_report;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog: five blocks and the register traffic take about 30 us
  initial begin
    #300000;
    n_errors++;
    final_report;
  end

  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    i_rst = 1'b1;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    n_errors = 0;
    comparisons = 0;
    n_samples = 0;
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    for (int a = 13; a < 16; a++) begin
      rd8(7'(a), d);
      check("status after reset", 24'(d), 24'h0);
    end
    rd8(7'h00, d);
    check("unmapped", 24'(d), 24'h0);
    rd8(scc_pkg::ADDR_RX_CFG, d);
    check("rx cfg reset", 24'(d), 24'(scc_pkg::RX_CFG_RESET));
    wr8(scc_pkg::ADDR_STATUS_BYTE_ZERO, 8'hff);
    rd8(scc_pkg::ADDR_STATUS_BYTE_ZERO, d);
    check("read-only write", 24'(d), 24'h0);
    check("irq idle", 24'(irq), 24'h0);
    // first block: 23-bit samples, left/right channel numbers
    u_src.send_frames(ST1, 0, 191);
    repeat (12) @(negedge i_clk);
    check("irq after block", 24'(irq), 24'h1);
    rd8(scc_pkg::ADDR_STATUS_BYTE_ZERO, d);
    check("status byte zero", 24'(d), 24'h06);
    check("irq after read", 24'(irq), 24'h0);
    rd8(scc_pkg::ADDR_CATEGORY_BYTE, d);
    check("category", 24'(d), 24'h42);
    rd8(scc_pkg::ADDR_SOURCE_CHANNEL_BYTE, d);
    check("source channel", 24'(d), 24'h95);
    sample(24'ha5c3e7, 1'b0);
    check("tx 23 bit", tx, 24'ha5c3e6);
    check("port 24 wide", adp, 24'ha5c3e6);
    check("sample channel", 24'(smp_first), 24'h0);
    // a first-channel sub-frame outside any block is passed on but not captured
    u_src.send_sub(1'b1, 1'b0, 1'b1, 1'b0, 24'h5a3c7f);
    repeat (4) @(negedge i_clk);
    check("sample first", 24'(smp_first), 24'h1);
    check("tx first channel", tx, 24'h5a3c7e);
    wr8(scc_pkg::ADDR_PORT_CFG, {6'h00, scc_pkg::PORT_W16});
    sample(24'ha5c3e7, 1'b0);
    check("port 16", adp, 24'ha5c300);
    check("tx beside port 16", tx, 24'ha5c3e6);
    wr8(scc_pkg::ADDR_PORT_CFG, {6'h00, scc_pkg::PORT_W20});
    wr8(scc_pkg::ADDR_RX_CFG, 8'he0);
    sample(24'ha5c3e7, 1'b1);
    check("tx masked", tx, 24'ha5c3e7);
    check("port 20 masked", adp, 24'ha5c3e0);
    check("user output enable", 24'(gpo_en), 24'h1);
    check("user output pin", 24'(general_output_pin), 24'h1);
    wr8(scc_pkg::ADDR_RX_CFG, 8'h80);
    wr8(scc_pkg::ADDR_PORT_CFG, {6'h00, scc_pkg::PORT_W24});
    check("user output off", 24'(gpo_en), 24'h0);
    check("user output pin off", 24'(general_output_pin), 24'h0);
    // second block: 20-bit samples, left unread
    u_src.send_frames(ST2, 0, 191);
    repeat (12) @(negedge i_clk);
    check("irq second block", 24'(irq), 24'h1);
    sample(24'ha5c3e7, 1'b0);
    check("tx 20 bit", tx, 24'ha5c3e0);
    check("port 24 over 20", adp, 24'ha5c3e0);
    // third block differs at bit 1 before the second was read
    u_src.send_frames(ST3, 0, 5);
    repeat (12) @(negedge i_clk);
    check("irq on new diff", 24'(irq), 24'h0);
    u_src.send_frames(ST3, 6, 191);
    repeat (12) @(negedge i_clk);
    check("irq reasserted", 24'(irq), 24'h1);
    rd8(scc_pkg::ADDR_SOURCE_CHANNEL_BYTE, d);
    check("channels swapped", 24'(d), 24'h62);
    rd8(scc_pkg::ADDR_CATEGORY_BYTE, d);
    check("general category", 24'(d), 24'h00);
    rd8(scc_pkg::ADDR_STATUS_BYTE_ZERO, d);
    check("status byte zero new", 24'(d), 24'h06);
    // same block again: nothing to report
    u_src.send_frames(ST3, 0, 191);
    repeat (12) @(negedge i_clk);
    check("irq on same block", 24'(irq), 24'h0);
    // fourth block: 18-bit samples, change in the length field only
    u_src.send_frames(ST4, 0, 191);
    repeat (12) @(negedge i_clk);
    check("irq length change", 24'(irq), 24'h1);
    sample(24'ha5c3e7, 1'b0);
    check("tx 18 bit", tx, 24'ha5c3c0);
    check("port 24 over 18", adp, 24'ha5c3c0);
    check("sample pulses", 24'(n_samples), 24'h786);
    final_report;
  end
endmodule
`default_nettype wire

// file: tb/scc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module scc_src_model (
  // recovered receive clock
  input wire logic i_rx_clk,
  // sub-frame stream toward the receiver
  output logic o_sub_valid,
  output logic o_sub_first,
  output logic o_block_start,
  output logic [27:0] o_sub_payload,
  output logic o_sub_cs,
  output logic o_sub_user
);
  initial begin
    o_sub_valid = 1'b0;
    o_sub_first = 1'b0;
    o_block_start = 1'b0;
    o_sub_payload = 28'h0000000;
    o_sub_cs = 1'b0;
    o_sub_user = 1'b0;
  end

  // ***************************************************************
  // one sub-frame, held for one receive clock
  // ***************************************************************
  // aux nibble carries junk so a slip in the audio slice shows up
  task automatic send_sub(input logic first, input logic start, input logic cs,
                          input logic user, input logic [23:0] audio);
    @(negedge i_rx_clk);
    o_sub_valid = 1'b1;
    o_sub_first = first;
    o_block_start = start;
    o_sub_payload = {audio, 4'ha};
    o_sub_cs = cs;
    o_sub_user = user;
    @(negedge i_rx_clk);
    // payload, status and user lines flip so a stale value never passes for live data
    o_sub_valid = 1'b0;
    o_sub_payload = ~o_sub_payload;
    o_sub_cs = ~cs;
    o_sub_user = ~user;
  endtask

  // ***************************************************************
  // frames lo..hi of a status block, both channels
  // ***************************************************************
  // length lives in status bits 32 and 35:33, second channel carries ones
  task automatic send_frames(input logic [39:0] st, input int lo, input int hi);
    for (int idx = lo; idx <= hi; idx++) begin
      send_sub(1'b1, idx == 0, (idx < 40) ? st[idx] : 1'b0, 1'b0, 24'h123456);
      send_sub(1'b0, 1'b0, 1'b1, 1'b0, 24'h654321);
    end
  endtask
endmodule
`default_nettype wire
